/* dds_host_model.sv */
/*
  Host serial master model: serial clock, chip select, sync reset, data pin.
  Assumes: the bench calls its tasks; the clock stands still between cycles.
*/
`timescale 1ns/1ps
module dds_host_model (
  output logic      link_clk,
  output logic      cs_n,
  output logic      io_sync_reset,
  output logic      sdio_in,
  input  wire logic sdio_out,
  input  wire logic sdio_oe_n,
  input  wire logic sdo_out,
  input  wire logic sdo_oe_n
);
  logic dir;       // Host owns the data line
  logic hval;      // Level the host puts on the line
  logic floated;   // Both pins seen released in a chip-select gap
  logic wrong_pin; // Unselected output pin drove during a read
  // A released line shows the inverse of the last host level, never a stale copy
  assign sdio_in = !sdio_oe_n ? sdio_out : (dir ? hval : !hval);
  initial
  begin
    link_clk = 1'b0;
    cs_n = 1'b1;
    io_sync_reset = 1'b0;
    dir = 1'b1;
    hval = 1'b0;
  end
  // Whole 15 ns periods; data only moves while the clock is low
  task automatic tick(input int n);
    repeat (n)
    begin
      #7.5 link_clk = 1'b1;
      #7.5 link_clk = 1'b0;
    end
  endtask : tick
  // One cycle: instruction then nb data bits; a gap opens before bit gap_at
  task automatic xfer(input logic [7:0] ins, input logic [31:0] wd, input int nb,
                      input bit lsb, input bit sdo, input int gap_at,
                      output logic [31:0] rd);
    rd = 32'h0;
    floated = 1'b0;
    wrong_pin = 1'b0;
    cs_n = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      hval = ins[lsb ? i : 7 - i]; // Instruction in the selected order
      tick(1);
    end
    dir = !ins[7];
    for (int i = 0; i < nb; i++)
    begin
      if (i == gap_at)
      begin
        cs_n = 1'b1;
        tick(2);
        // Reselect while the clock is high, so a falling edge re-drives the pin
        #7.5 link_clk = 1'b1;
        #3.75 floated = sdio_oe_n & sdo_oe_n;
        cs_n = 1'b0;
        #3.75 link_clk = 1'b0;
      end
      hval = wd[lsb ? i : nb - 1 - i]; // Data bit in the selected order; nb is not checked against the register length
      #7.5 link_clk = 1'b1;
      rd[lsb ? i : nb - 1 - i] = sdo ? sdo_out : sdio_in;
      if (ins[7])
        wrong_pin = wrong_pin | (sdo ? !sdio_oe_n : !sdo_oe_n);
      #7.5 link_clk = 1'b0;
    end
    cs_n = 1'b1;
    dir = 1'b1;
    tick(1);
  endtask : xfer
  // Sync reset is back low before the next instruction starts
  task automatic resync();
    cs_n = 1'b0;
    io_sync_reset = 1'b1;
    tick(1);
    io_sync_reset = 1'b0;
    cs_n = 1'b1;
    tick(1);
  endtask : resync
endmodule : dds_host_model

/* dds_serial_pkg.sv */
/*
  Shared constants, types and helpers for the serial programming port and
  bank update logic of the synthesizer.
  Assumes: imported by the serial port module and its bench; sync_2ff and the host model do not import it.
*/
package dds_serial_pkg;

  // Register map: serial addresses and the printed byte offsets
  localparam logic [3:0] ADDR_UPDATE_INTERVAL = 4'h5;   // 4-byte update interval
  localparam logic [3:0] ADDR_CTRL_WORD       = 4'h7;   // 4-byte control word
  localparam logic [7:0] CTRL_WORD_OFFSET     = 8'h1d;  // Control word spans 1d..20
  localparam logic [7:0] SER_CFG_OFFSET       = 8'h20;  // Byte holding serial config

  // Instruction byte layout
  localparam int         INSTR_BITS  = 8;               // Bits per instruction
  localparam int         INSTR_RD    = 7;               // 1 = read, 0 = write
  localparam int         INSTR_ADDR_HI = 3;             // Address in bits 3..0

  // Control word field positions
  localparam int         CW_SDO_ACTIVE = 0;             // Separate output pin in use
  localparam int         CW_LSB_FIRST  = 1;             // Bit order of the port
  localparam int         CW_INT_UPDATE = 8;             // Internal update mode
  localparam int         CW_MULT_LO    = 16;            // Multiplier factor low bit
  localparam int         CW_MULT_HI    = 20;            // Multiplier factor high bit
  localparam int         CW_PLL_BYPASS = 21;            // Reference clocks system
  localparam int         CW_PLL_RANGE  = 22;            // Oscillator gain range
  localparam int         CW_DIG_PD     = 24;            // Digital power-down
  localparam int         CW_DACS_PD    = 25;            // Both converters and reference
  localparam int         CW_QDAC_PD    = 26;            // Q converter power-down
  localparam int         CW_HALT       = 27;            // Must be written as zero
  localparam int         CW_CMP_PD     = 28;            // Comparator power-down

  // Values after reset
  localparam logic [31:0] CTRL_WORD_RESET       = 32'h0060_0000; // Range and bypass set
  localparam logic [31:0] UPDATE_INTERVAL_RESET = 32'h0000_0040;

  // Timing in system clock cycles; serial clock limit in MHz
  localparam logic [3:0]  STROBE_MIN_HIGH = 4'h8;        // Least strobe high time
  localparam logic [31:0] STROBE_STUCK_LIMIT = 32'h0000_0005; // Below this: always high
  localparam int          EXT_MIN_HIGH    = 2;            // Host strobe high time
  localparam int          SCLK_MAX_MHZ    = 10;           // Host serial clock limit

  // Signals to the analog and clocking sections
  typedef struct packed {
    logic       cmp_pd;          // Comparator power-down
    logic       qdac_pd;         // Q converter power-down
    logic       dacs_pd;         // Both converters and reference
    logic       digital_clk_en;  // Low holds digital clocks static
    logic       pll_range;       // Oscillator gain range
    logic       pll_bypass;      // Reference drives system clock
    logic [4:0] pll_mult;        // Reference multiplication factor
  } analog_ctrl_type;

  // Serial port phases
  typedef enum logic {PH_INSTR, PH_DATA} phase_type;

  // Data bits expected after the instruction, by register address
  function automatic logic [5:0] data_bits(input logic [3:0] addr);
    logic [5:0] n;
    n = 6'h10;
    unique case (addr)
      4'h2, 4'h3, 4'h4: n = 6'h30;
      4'h5, 4'h7:       n = 6'h20;
      4'h6:             n = 6'h18;
      default:          n = 6'h10;
    endcase
    return n;
  endfunction : data_bits

endpackage : dds_serial_pkg

/* dds_serial_port_update_ctrl.sv */
/*
  Serial programming port of the synthesizer with its write buffer, the
  buffer-to-bank update logic and the upper control word outputs.
  Assumes: the host is the serial master and moves sdio, cs_n and
  io_sync_reset in step with link_clk; srst is held long enough for the
  link clock to see it; the strobe pin wire is resolved outside.
*/
// Summary of operation
// - Chip select high floats both data pins
// - Chip select high pauses, low resumes cycle
// - Config bit 0 chooses pin mode, default bidirectional
// - Bidirectional mode leaves separate output floating
// - Sync reset ends cycle, keeps registers
// - After sync reset, eight edges form instruction
// - Config change acts at update, mid-cycle
// - Exact register byte count, then next instruction
// - Completed writes survive sync reset recovery
// - Config bit 1 selects LSB-first order
// - Writes buffered, moved to bank on clk
// - External strobe rising edge: exactly one transfer
// - Internal mode drives strobe, eight clocks high
// - Interval below five keeps strobe high
// - Automatic update every twice the interval
// - Control word is 32 bits at 1d-20
// - Four power-down bits, active high, default zero
// - Digital power-down stops digital clocks only
// - Control bit 27 one halts until reset
// - Range and bypass bits come up set
// - Instruction bit 7 is read, 6-4 ignored
// - Instruction bits 3-0 pick register, length
// - Sample on rising, drive on falling edge
// - Control bit 8 selects internal update mode
`timescale 1ns/1ps
module dds_serial_port_update_ctrl
  import dds_serial_pkg::*;
(
  input  wire logic      clk,                 // System clock, 25 MHz
  input  wire logic      srst,                // Master reset, synchronous
  input  wire logic      link_clk,            // Serial clock from the host
  input  wire logic      cs_n,                // Chip select
  input  wire logic      io_sync_reset,       // Port resynchronise
  input  wire logic      sdio_in,             // Data pin, level seen
  output logic           sdio_out,            // Data pin, level driven
  output logic           sdio_oe_n,           // Data pin drive, low drives
  output logic           sdo_out,             // Separate output pin
  output logic           sdo_oe_n,            // Separate output drive, low drives
  input  wire logic      bank_update_strobe_in,   // Strobe pin, level seen
  output logic           bank_update_strobe_out,  // Strobe pin, level driven
  output logic           bank_update_strobe_oe_n, // Strobe drive, low drives
  output analog_ctrl_type analog_ctrl,        // Active power and multiplier bits
  output logic           halted               // Stopped by control bit 27
);

  // Link domain state
  phase_type   phase_q;       // Instruction or data phase
  logic [5:0]  bit_cnt_q;     // Bits taken in the current phase
  logic [7:0]  instr_q;       // Instruction of the current cycle
  logic [7:0]  instr_sh_q;    // Instruction being shifted in
  logic [31:0] rx_sh_q;       // Data being shifted in
  logic [31:0] tx_sh_q;       // Data being shifted out
  logic [31:0] ctrl_buf_q;    // Buffered control word
  logic [31:0] ivl_buf_q;     // Buffered update interval
  logic        commit_tgl_q;  // Flips after each complete write
  logic        rst_lk;        // Master reset seen in link domain
  logic [1:0]  cfg_lk;        // Serial config bits seen in link domain

  // System domain state
  logic [31:0] ctrl_pend_q;   // Buffer copy held in system domain
  logic [31:0] ivl_pend_q;
  logic [31:0] ctrl_act_q;    // Active bank
  logic [31:0] ivl_act_q;
  logic        tgl_sys;       // Commit toggle after crossing
  logic        tgl_seen_q;    // Last toggle value taken
  logic        ud_sys;        // Strobe pin after crossing
  logic        ud_prev_q;     // For the rising-edge detector
  logic [32:0] ivl_cnt_q;     // Cycles since the last automatic update
  logic [3:0]  stretch_q;     // Remaining strobe high time
  logic        xfer;          // Buffer copy moves to the bank this cycle
  logic        int_mode;      // Internal update mode active
  logic        tick;          // Automatic update due
  logic        stuck;         // Interval too short for a visible pulse
  logic [32:0] period_m1;     // Twice the interval, minus one

  // Combinational shift values, order chosen by the config bit
  logic        lsb_first;
  logic [7:0]  instr_next;
  logic [31:0] rx_next;
  logic [5:0]  last_bit;
  logic        tx_bit;

  // Crossings: master reset and config bits into the link domain
  sync_2ff #(.WIDTH(3)) u_sync_lk (
    .clk  (link_clk),
    .din  ({srst, ctrl_act_q[CW_LSB_FIRST], ctrl_act_q[CW_SDO_ACTIVE]}),
    .dout ({rst_lk, cfg_lk})
  );

  // Crossings: commit toggle and strobe pin into the system domain
  sync_2ff #(.WIDTH(2)) u_sync_sys (
    .clk  (clk),
    .din  ({commit_tgl_q, bank_update_strobe_in}),
    .dout ({tgl_sys, ud_sys})
  );

  // Shift helpers; order follows the bank value after an update
  always_comb
  begin
    lsb_first  = cfg_lk[1];
    instr_next = lsb_first ? {sdio_in, instr_sh_q[7:1]}
                           : {instr_sh_q[6:0], sdio_in};
    rx_next    = lsb_first ? {sdio_in, rx_sh_q[31:1]}
                           : {rx_sh_q[30:0], sdio_in};
    last_bit   = data_bits(instr_q[INSTR_ADDR_HI:0]) - 6'h01;
    tx_bit     = lsb_first ? tx_sh_q[0] : tx_sh_q[31];
  end

  // Phase sequencer on rising serial clock edges
  always_ff @(posedge link_clk)
  begin
    if (rst_lk || io_sync_reset)
    begin
      // Either reset leaves the port waiting for an instruction
      phase_q   <= PH_INSTR;
      bit_cnt_q <= 6'h00;
      instr_q   <= 8'h00;
    end
    else if (!cs_n)
    begin
      // Nothing advances while deselected, so a cycle resumes in place
      unique case (phase_q)
        PH_INSTR:
        begin
          if (bit_cnt_q == 6'(INSTR_BITS - 1))
          begin
            phase_q   <= PH_DATA;
            bit_cnt_q <= 6'h00;
            instr_q   <= instr_next;
          end
          else
          begin
            bit_cnt_q <= bit_cnt_q + 6'h01;
          end
        end
        PH_DATA:
        begin
          if (bit_cnt_q == last_bit)
          begin
            // Exact count reached; the next edge opens an instruction
            phase_q   <= PH_INSTR;
            bit_cnt_q <= 6'h00;
          end
          else
          begin
            bit_cnt_q <= bit_cnt_q + 6'h01;
          end
        end
      endcase
    end
  end

  // Input and output shifters, data sampled on rising edges
  always_ff @(posedge link_clk)
  begin
    if (rst_lk)
    begin
      instr_sh_q <= 8'h00;
      rx_sh_q    <= 32'h0000_0000;
      tx_sh_q    <= 32'h0000_0000;
    end
    else if (!cs_n && !io_sync_reset)
    begin
      if (phase_q == PH_INSTR)
      begin
        instr_sh_q <= instr_next;
        // Load read data as the instruction completes
        if (bit_cnt_q == 6'(INSTR_BITS - 1))
        begin
          unique case (instr_next[INSTR_ADDR_HI:0])
            ADDR_CTRL_WORD:       tx_sh_q <= ctrl_buf_q;
            ADDR_UPDATE_INTERVAL: tx_sh_q <= ivl_buf_q;
            default:              tx_sh_q <= 32'h0000_0000;     // Not held here
          endcase
        end
      end
      else
      begin
        rx_sh_q <= rx_next;
        tx_sh_q <= lsb_first ? {1'b0, tx_sh_q[31:1]} : {tx_sh_q[30:0], 1'b0};
      end
    end
  end

  // Write buffer; only a full data phase lands, so partial cycles vanish
  always_ff @(posedge link_clk)
  begin
    if (rst_lk)
    begin
      ctrl_buf_q   <= CTRL_WORD_RESET;
      ivl_buf_q    <= UPDATE_INTERVAL_RESET;
      commit_tgl_q <= 1'b0;
    end
    else if (!cs_n && !io_sync_reset && phase_q == PH_DATA &&
             bit_cnt_q == last_bit && !instr_q[INSTR_RD])
    begin
      // Buffered only; the bank follows at the next update
      if (instr_q[INSTR_ADDR_HI:0] == ADDR_CTRL_WORD)
      begin
        ctrl_buf_q <= rx_next;
      end
      if (instr_q[INSTR_ADDR_HI:0] == ADDR_UPDATE_INTERVAL)
      begin
        ivl_buf_q <= rx_next;
      end
      commit_tgl_q <= ~commit_tgl_q;
    end
  end

  // Output data changes on falling edges
  always_ff @(negedge link_clk)
  begin
    if (rst_lk)
    begin
      sdio_out  <= 1'b0;
      sdo_out   <= 1'b0;
    end
    else
    begin
      sdio_out  <= tx_bit;
      sdo_out   <= tx_bit;
    end
  end

  // Enables: deselect floats both pins at once, even with the serial clock
  // parked, so a cut read never leaves a pin driven
  always_ff @(negedge link_clk or posedge cs_n)
  begin
    if (cs_n)
    begin
      sdio_oe_n <= 1'b1;
      sdo_oe_n  <= 1'b1;
    end
    else if (rst_lk)
    begin
      sdio_oe_n <= 1'b1;
      sdo_oe_n  <= 1'b1;
    end
    else
    begin
      sdio_oe_n <= !(phase_q == PH_DATA && instr_q[INSTR_RD] && !cfg_lk[0]);
      sdo_oe_n  <= !(phase_q == PH_DATA && instr_q[INSTR_RD] && cfg_lk[0]);
    end
  end

  // Take the buffer once its toggle has crossed; it is stable by then
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tgl_seen_q  <= 1'b0;
      ctrl_pend_q <= CTRL_WORD_RESET;
      ivl_pend_q  <= UPDATE_INTERVAL_RESET;
    end
    else if (tgl_sys != tgl_seen_q)
    begin
      tgl_seen_q  <= tgl_sys;
      ctrl_pend_q <= ctrl_buf_q;
      ivl_pend_q  <= ivl_buf_q;
    end
  end

  // Update decision: strobe edge or interval timer, halted blocks both
  always_comb
  begin
    int_mode  = ctrl_act_q[CW_INT_UPDATE];
    period_m1 = {ivl_act_q, 1'b0} - 33'h0_0000_0001;
    tick      = (ivl_act_q == 32'h0000_0000) || (ivl_cnt_q >= period_m1);
    stuck     = ivl_act_q < STROBE_STUCK_LIMIT;
    xfer      = !halted && (int_mode ? tick : (ud_sys && !ud_prev_q));
  end

  // Interval timer and strobe edge memory
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ivl_cnt_q <= 33'h0_0000_0000;
      ud_prev_q <= 1'b0;
    end
    else
    begin
      ud_prev_q <= ud_sys;                                       // Held high: no repeat
      ivl_cnt_q <= (!int_mode || tick) ? 33'h0_0000_0000
                                       : ivl_cnt_q + 33'h0_0000_0001;
    end
  end

  // Active bank: the only state that steers operation
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_act_q <= CTRL_WORD_RESET;
      ivl_act_q  <= UPDATE_INTERVAL_RESET;
    end
    else if (xfer)
    begin
      ctrl_act_q <= ctrl_pend_q;
      ivl_act_q  <= ivl_pend_q;
    end
  end

  // Bit 27 blocks bank transfers until master reset
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      halted <= 1'b0;
    end
    else if (ctrl_act_q[CW_HALT])
    begin
      halted <= 1'b1;
    end
  end

  // Strobe pin: output only in internal mode, pulse stretched to eight
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      stretch_q               <= 4'h0;
      bank_update_strobe_out  <= 1'b0;
      bank_update_strobe_oe_n <= 1'b1;
    end
    else
    begin
      if (xfer && int_mode)
      begin
        stretch_q <= STROBE_MIN_HIGH;
      end
      else if (stretch_q != 4'h0)
      begin
        stretch_q <= stretch_q - 4'h1;
      end
      // A short interval would chop pulses, so the pin just stays high
      bank_update_strobe_out  <= int_mode && ((xfer) || (stretch_q > 4'h1) ||
                                              stuck);
      bank_update_strobe_oe_n <= !int_mode;
    end
  end

  // Power-down and multiplier outputs follow the active bank
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      analog_ctrl <= '{cmp_pd: 1'b0, qdac_pd: 1'b0, dacs_pd: 1'b0,
                       digital_clk_en: 1'b1, pll_range: 1'b1,
                       pll_bypass: 1'b1, pll_mult: 5'h00};
    end
    else
    begin
      analog_ctrl.cmp_pd     <= ctrl_act_q[CW_CMP_PD];
      analog_ctrl.qdac_pd    <= ctrl_act_q[CW_QDAC_PD];
      analog_ctrl.dacs_pd    <= ctrl_act_q[CW_DACS_PD];
      // Multiplier loop fields stay live while digital clocks stop
      analog_ctrl.digital_clk_en <= !ctrl_act_q[CW_DIG_PD];
      analog_ctrl.pll_range  <= ctrl_act_q[CW_PLL_RANGE];
      analog_ctrl.pll_bypass <= ctrl_act_q[CW_PLL_BYPASS];
      analog_ctrl.pll_mult   <= ctrl_act_q[CW_MULT_HI:CW_MULT_LO];
    end
  end

  // Checks, system domain
  sequence s_strobe_pulse;
    bank_update_strobe_out [*8];
  endsequence

  a_ext_single_xfer : assert property (@(posedge clk) disable iff (srst)
    (!int_mode && xfer) |=> !xfer [*2])
    else $error("external strobe caused repeated transfer");

  a_int_strobe_width : assert property (@(posedge clk) disable iff (srst)
    (int_mode && xfer) |=> s_strobe_pulse)
    else $error("internal strobe pulse shorter than eight clocks");

  a_strobe_stuck_high : assert property (@(posedge clk) disable iff (srst)
    (int_mode && stuck && $stable(ctrl_act_q) && $stable(ivl_act_q))
      |=> bank_update_strobe_out)
    else $error("strobe fell with interval below five");

  a_interval_period : assert property (@(posedge clk) disable iff (srst)
    (int_mode && xfer && !stuck && $stable(ivl_act_q) && $stable(ctrl_act_q))
      |-> $past(ivl_cnt_q) == period_m1 - 33'h0_0000_0001)
    else $error("automatic update off its period");

  a_digital_pd_map : assert property (@(posedge clk) disable iff (srst)
    $past(ctrl_act_q[CW_DIG_PD]) |-> !analog_ctrl.digital_clk_en)
    else $error("digital clocks run during power-down");

  a_halt_blocks : assert property (@(posedge clk) disable iff (srst)
    halted |-> !xfer && $stable(ctrl_act_q))
    else $error("bank updated while halted");

  a_reset_defaults : assert property (@(posedge clk)
    $past(srst) |-> ctrl_act_q == CTRL_WORD_RESET && analog_ctrl.pll_bypass)
    else $error("control word not at defaults after reset");

  // Checks, link domain
  a_deselect_float : assert property (@(negedge link_clk) disable iff (rst_lk)
    cs_n |=> sdio_oe_n && sdo_oe_n)
    else $error("data pins driven while deselected");

  a_sync_reset_idle : assert property (@(posedge link_clk) disable iff (rst_lk)
    io_sync_reset |=> phase_q == PH_INSTR && bit_cnt_q == 6'h00 && $stable(ctrl_buf_q))
    else $error("sync reset did not return to instruction phase");

  a_cs_suspend : assert property (@(posedge link_clk) disable iff (rst_lk)
    (cs_n && !io_sync_reset) |=> $stable(bit_cnt_q) && $stable(phase_q))
    else $error("cycle advanced while deselected");

endmodule : dds_serial_port_update_ctrl

/* dds_serial_port_update_ctrl_test.sv */
/*
  Self-checking bench for the serial port and bank update logic.
  Assumes: dds_host_model is the serial master; the strobe pin is resolved here.
*/
`timescale 1ns/1ps
module dds_serial_port_update_ctrl_test;
  import dds_serial_pkg::*;
  logic            clk, srst, link_clk, cs_n, io_sync_reset, sdio_in, sdio_out, halted;
  logic            sdio_oe_n, sdo_out, sdo_oe_n, ud_drv, ud_out, ud_oe_n, ud_pin;
  analog_ctrl_type act;
  logic [31:0]     rd;
  int              err_total, samples_checked, cyc, hi, per;
  // Device wins the strobe pin when it drives it
  assign ud_pin = !ud_oe_n ? ud_out : ud_drv;
  initial clk = 1'b0;
  always #20 clk = ~clk;
  dds_serial_port_update_ctrl dut (.clk(clk), .srst(srst), .link_clk(link_clk),
    .cs_n(cs_n), .io_sync_reset(io_sync_reset), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe_n(sdio_oe_n), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
    .bank_update_strobe_in(ud_pin), .bank_update_strobe_out(ud_out),
    .bank_update_strobe_oe_n(ud_oe_n), .analog_ctrl(act), .halted(halted));
  dds_host_model host (.link_clk(link_clk), .cs_n(cs_n), .io_sync_reset(io_sync_reset),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .sdo_out(sdo_out),
    .sdo_oe_n(sdo_oe_n));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d, errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  // External strobe held three clocks, above the two-clock minimum
  task automatic ud_pulse();
    @(negedge clk) ud_drv = 1'b1;
    repeat (3) @(negedge clk);
    ud_drv = 1'b0;
    repeat (8) @(negedge clk);
  endtask : ud_pulse
  // High time and period of the strobe output, bounded waits
  task automatic time_strobe();
    hi = 0;
    per = 0;
    while (!ud_out && per < 100) @(negedge clk) per++;
    per = 0;
    while (ud_out && per < 100) @(negedge clk) begin hi++; per++; end
    while (!ud_out && per < 100) @(negedge clk) per++;
  endtask : time_strobe
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      err_total++;
      complete_run();
    end
  end
  initial
  begin
    srst = 1'b1;
    ud_drv = 1'b0;
    fork
      host.tick(12);
      repeat (4) @(negedge clk);
    join
    @(negedge clk) srst = 1'b0;
    host.tick(4);
    check(act, 32'h0e0, "reset controls");
    check({sdio_oe_n, sdo_oe_n, ud_oe_n, halted}, 32'he, "reset pins");
    host.xfer(8'h07, 32'h132a_0000, 32, 0, 0, -1, rd);
    repeat (10) @(negedge clk);
    check(act, 32'h0e0, "write acted before update");
    ud_pulse();
    check(act, 32'h52a, "controls after update");
    host.xfer(8'h87, 32'h0, 32, 0, 0, 10, rd);
    check(rd, 32'h132a_0000, "paused read");
    check({host.floated, host.wrong_pin}, 32'h2, "pins in gap");
    @(negedge clk) ud_drv = 1'b1;
    host.xfer(8'h07, 32'h0060_0000, 32, 0, 0, -1, rd);
    repeat (20) @(negedge clk);
    check(act, 32'h52a, "held strobe repeated");
    ud_drv = 1'b0;
    host.xfer(8'h07, 32'hffff_ffff, 16, 0, 0, -1, rd);
    host.resync();
    host.xfer(8'h00, 32'h0, 16, 0, 0, -1, rd);
    host.xfer(8'hf7, 32'h0, 32, 0, 0, -1, rd);
    check(rd, 32'h0060_0000, "read after resync");
    ud_pulse();
    check({act, halted}, 32'h1c0, "partial write lost");
    host.xfer(8'h05, 32'd10, 32, 0, 0, -1, rd);
    host.xfer(8'h07, 32'h0060_0103, 32, 0, 0, -1, rd);
    ud_pulse();
    time_strobe();
    check(ud_oe_n, 32'h0, "strobe not driven");
    check(hi, 32'd8, "strobe high time");
    check(per, 32'd20, "update period");
    // New config bits reach the link side only after two serial clocks
    host.tick(2);
    host.xfer(8'h87, 32'h0, 32, 1, 1, -1, rd);
    check(rd, 32'h0060_0103, "lsb read on sdo");
    check(host.wrong_pin, 32'h0, "data pin drove");
    host.xfer(8'h05, 32'd3, 32, 1, 1, -1, rd);
    host.xfer(8'h07, 32'h046c_0103, 32, 1, 1, -1, rd);
    repeat (40) @(negedge clk);
    check(act, 32'h2ec, "automatic transfer");
    repeat (16) @(negedge clk) check(ud_out, 32'h1, "strobe dropped");
    // Stop bit written, then a master reset in mid-run
    host.xfer(8'h07, 32'h0860_0103, 32, 1, 1, -1, rd);
    repeat (40) @(negedge clk);
    check({act, halted}, 32'h1c1, "halt bit");
    @(negedge clk) srst = 1'b1;
    fork
      host.tick(4);
      repeat (4) @(negedge clk);
    join
    @(negedge clk) srst = 1'b0;
    host.tick(4);
    check({act, halted}, 32'h1c0, "reset ends halt");
    complete_run();
  end
endmodule : dds_serial_port_update_ctrl_test

/* sync_2ff.sv */
/*
  Two flip-flop level synchroniser, one bit lane per WIDTH.
  Assumes: each lane is a level or a toggle that stays put for several
  destination clocks; the first stage is read by the second stage only.
*/
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;  // First stage, may go metastable

  // Plain two-stage chain, no reset so nothing else touches stage one
  always_ff @(posedge clk)
  begin
    meta_q <= din;
    dout   <= meta_q;
  end

endmodule : sync_2ff
